// File: src/lpd_pwm_core.sv
// Purpose: Six-channel LED PWM path with ramp, dither, stagger and AXI4-Lite registers
// Assumes: One 10 MHz clock; pin inputs are asynchronous and synchronised here
// Notes:   Generation ticks are divided from aclk; 40 MHz setting runs one tick per cycle
`timescale 1ns/1ps
module lpd_pwm_core #(
  parameter int unsigned SLOPE_FULL_CYC = lpd_pkg::SLOPE_MAX_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address, data and response
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Brightness sources and frequency-set resistor
  input  wire logic [12:0] detected_duty,
  input  wire logic        pwm_in,
  input  wire logic [2:0]  freq_set_resistor,
  // LED drive
  output logic [5:0]       led_out,
  output logic [7:0]       current_level,
  output logic             current_resistor_enable
);

  // ----------------------------------------------------------------
  // Registers and AXI4-Lite slave
  // ----------------------------------------------------------------
  lpd_pkg::lpd_cfg_s cfg_q;
  logic [7:0]        brt_q;
  logic [7:0]        cur_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [31:0]       cfg_word;
  logic [31:0]       status_word;
  logic [31:0]       duty_word;
  logic [31:0]       cfg_merged;
  logic [31:0]       brt_merged;
  logic [31:0]       cur_merged;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign cfg_word      = {14'h0000, cfg_q};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = old;
  endfunction

  assign cfg_merged = merge(cfg_word, wdata_q, wstrb_q);
  assign brt_merged = merge({24'h0, brt_q}, wdata_q, wstrb_q);
  assign cur_merged = merge({24'h0, cur_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else if (aw_have_q && w_have_q) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q        <= lpd_pkg::lpd_cfg_s'(lpd_pkg::CFG_RESET[17:0]);
      brt_q        <= lpd_pkg::BRT_RESET;
      cur_q        <= lpd_pkg::CUR_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= lpd_pkg::RESP_OKAY;
    end else if (aw_have_q && w_have_q) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= lpd_pkg::RESP_OKAY;
      if (awaddr_q == lpd_pkg::ADDR_CFG) begin
        cfg_q <= lpd_pkg::lpd_cfg_s'(cfg_merged[17:0]);
      end else if (awaddr_q == lpd_pkg::ADDR_BRT) begin
        brt_q <= brt_merged[7:0];
      end else if (awaddr_q == lpd_pkg::ADDR_CUR) begin
        cur_q <= cur_merged[7:0];
      end else if (awaddr_q == lpd_pkg::ADDR_STATUS || awaddr_q == lpd_pkg::ADDR_DUTY) begin
        s_axi_bresp <= lpd_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= lpd_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= lpd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= lpd_pkg::RESP_OKAY;
      if (s_axi_araddr == lpd_pkg::ADDR_CFG) begin
        s_axi_rdata <= cfg_word;
      end else if (s_axi_araddr == lpd_pkg::ADDR_BRT) begin
        s_axi_rdata <= {24'h0, brt_q};
      end else if (s_axi_araddr == lpd_pkg::ADDR_CUR) begin
        s_axi_rdata <= {24'h0, cur_q};
      end else if (s_axi_araddr == lpd_pkg::ADDR_STATUS) begin
        s_axi_rdata <= status_word;
      end else if (s_axi_araddr == lpd_pkg::ADDR_DUTY) begin
        s_axi_rdata <= duty_word;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= lpd_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Current code passes straight to the sink DAC
  assign current_level           = cur_q;
  assign current_resistor_enable = cfg_q.current_resistor_enable;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pwm_sync_q;
  logic [2:0] rset_meta_q;
  logic [2:0] rset_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_sync_q  <= 2'b00;
      rset_meta_q <= 3'h0;
      rset_q      <= 3'h0;
    end else begin
      pwm_sync_q  <= {pwm_sync_q[0], pwm_in};
      rset_meta_q <= freq_set_resistor;
      rset_q      <= rset_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Source select, ramp and resolution
  // ----------------------------------------------------------------
  logic [15:0] src_brt;
  logic [15:0] ramp_val;
  logic        ramping;
  logic        direct_mode;
  logic [4:0]  code_eff;
  logic [3:0]  res_eff;
  logic [1:0]  gsel_eff;

  assign direct_mode = (cfg_q.brightness_source_sel == lpd_pkg::SRC_DIRECT);
  assign src_brt     = (cfg_q.brightness_source_sel == lpd_pkg::SRC_REG) ? {brt_q, 8'h00}
                                                                          : {detected_duty, 3'b000};

  lpd_sloper #(
    .SLOPE_FULL_CYC (SLOPE_FULL_CYC)
  ) lpd_sloper_i (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .target     (src_brt),
    .slope_code (cfg_q.slope_code),
    .value_q    (ramp_val),
    .ramping    (ramping)
  );

  // Resistor range overrides the code with a limited subset
  assign code_eff = cfg_q.freq_resistor_enable ? lpd_pkg::freq_set_resistor_code(cfg_q.gen_clock_sel_short, rset_q)
                                               : cfg_q.period_code;
  assign res_eff  = lpd_pkg::res_bits(code_eff);
  // Too-fast pairings fall back to the fastest allowed clock for this code
  assign gsel_eff = (res_eff >= 4'd8 + {2'b00, cfg_q.gen_clock_sel_short}) ? cfg_q.gen_clock_sel_short
                                                                           : 2'(res_eff - 4'd8);

  // ----------------------------------------------------------------
  // Generation tick divider
  // ----------------------------------------------------------------
  logic [2:0] tick_cnt_q;
  logic       gen_tick;

  assign gen_tick = (tick_cnt_q == (3'h7 >> gsel_eff));

  always_ff @(posedge aclk) begin
    if (!aresetn || gen_tick) begin
      tick_cnt_q <= 3'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Period counter, dither and duty
  // ----------------------------------------------------------------
  logic [13:0] cnt_q;
  logic [13:0] period_q;
  logic [13:0] shift_q;
  logic [13:0] duty_q;
  logic [2:0]  pidx_q;
  logic        dith_on_q;
  logic        period_end;
  logic [13:0] per_next;
  logic [15:0] base_duty;
  logic [15:0] ext_val;
  logic [2:0]  frac;
  logic [2:0]  dmask;
  logic        dith_on;
  logic        extra;
  logic [13:0] duty_next;

  assign period_end = gen_tick && (cnt_q >= period_q - 14'h1);
  assign per_next   = lpd_pkg::period_ticks(code_eff);
  // Only the resolution MSBs; dither bits never size the resolution
  assign base_duty  = ramp_val >> (5'd16 - {1'b0, res_eff});
  assign ext_val    = ramp_val >> (5'd16 - {1'b0, res_eff} - {3'b000, cfg_q.dither_bits});
  assign dmask      = 3'((4'h1 << cfg_q.dither_bits) - 4'h1);
  assign frac       = ext_val[2:0] & dmask;
  assign dith_on    = ramping && (cfg_q.slope_code != 4'h0) && (cfg_q.dither_bits != 2'b00);
  // frac of every 2^N periods get one extra LSB
  assign extra      = dith_on && (((pidx_q + 3'h1) & dmask) < frac);
  assign duty_next  = base_duty[13:0] + {13'h0, extra};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q     <= 14'h0000;
      period_q  <= 14'h0001;
      shift_q   <= 14'h0000;
      duty_q    <= 14'h0000;
      pidx_q    <= 3'h0;
      dith_on_q <= 1'b0;
    end else if (period_end) begin
      cnt_q     <= 14'h0000;
      period_q  <= per_next;
      shift_q   <= cfg_q.stagger_enable ? (per_next / 14'd6) : 14'h0000;
      duty_q    <= duty_next;
      pidx_q    <= pidx_q + 3'h1;
      dith_on_q <= dith_on;
    end else if (gen_tick) begin
      cnt_q <= cnt_q + 14'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel comparators
  // ----------------------------------------------------------------
  logic [5:0] cmp;

  for (genvar k = 0; k < lpd_pkg::NUM_CH; k++) begin : g_ch
    logic [16:0] dly;
    logic [13:0] ch_cnt;
    assign dly    = 17'(shift_q) * 17'(k);
    assign ch_cnt = (cnt_q >= dly[13:0]) ? (cnt_q - dly[13:0]) : (cnt_q + period_q - dly[13:0]);
    assign cmp[k] = (ch_cnt < duty_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_out <= 6'h00;
    end else if (direct_mode) begin
      // Direct mode bypasses ramp, dither and stagger
      led_out <= {6{pwm_sync_q[1]}};
    end else if (gen_tick) begin
      led_out <= cmp;
    end
  end

  assign status_word = {2'b00, led_out, 1'b0, gsel_eff, res_eff, ramping, ramp_val};
  assign duty_word   = {17'h0, dith_on_q, duty_q};

endmodule

// File: src/lpd_pkg.sv
// Purpose: Shared constants, configuration layout and period tables for the LED PWM path
// Assumes: 10 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   Period counts are in generation-clock ticks, derived from the 5 MHz column
package lpd_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10000000;
  localparam int unsigned SLOPE_MAX_MS  = 500;
  localparam int unsigned SLOPE_MAX_CYC = SLOPE_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned SLOPE_CODES   = 15;
  localparam int unsigned NUM_CH        = 6;
  localparam int unsigned PERIOD_W      = 14;
  localparam int unsigned BRT_W         = 16;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_BRT    = 8'h04;
  localparam logic [7:0] ADDR_CUR    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_DUTY   = 8'h10;

  // Configuration field positions
  localparam int unsigned CFG_SLOPE_LSB  = 0;
  localparam int unsigned CFG_DITHER_LSB = 4;
  localparam int unsigned CFG_GSEL_LSB   = 6;
  localparam int unsigned CFG_PCODE_LSB  = 8;
  localparam int unsigned CFG_STAG_BIT   = 13;
  localparam int unsigned CFG_FRES_BIT   = 14;
  localparam int unsigned CFG_SRC_LSB    = 15;
  localparam int unsigned CFG_IRES_BIT   = 17;

  // Status field positions
  localparam int unsigned ST_RAMP_BIT = 16;
  localparam int unsigned ST_RES_LSB  = 17;
  localparam int unsigned ST_GSEL_LSB = 21;
  localparam int unsigned ST_LED_LSB  = 24;

  // Reset values
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [7:0]  BRT_RESET = 8'h00;
  localparam logic [7:0]  CUR_RESET = 8'hff;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Brightness source encodings
  localparam logic [1:0] SRC_DIRECT = 2'b11;
  localparam logic [1:0] SRC_REG    = 2'b10;

  typedef struct packed {
    logic       current_resistor_enable;
    logic [1:0] brightness_source_sel;
    logic       freq_resistor_enable;
    logic       stagger_enable;
    logic [4:0] period_code;
    logic [1:0] gen_clock_sel_short;
    logic [1:0] dither_bits;
    logic [3:0] slope_code;
  } lpd_cfg_s;

  // Steady resolution for each period code
  function automatic logic [3:0] res_bits(input logic [4:0] code);
    if (code >= 5'd28) begin
      res_bits = 4'd8;
    end else if (code >= 5'd25) begin
      res_bits = 4'd9;
    end else if (code >= 5'd9) begin
      res_bits = 4'd10;
    end else if (code >= 5'd4) begin
      res_bits = 4'd11;
    end else if (code >= 5'd1) begin
      res_bits = 4'd12;
    end else begin
      res_bits = 4'd13;
    end
  endfunction

  // Period in generation ticks; the tick rate then scales the frequency
  function automatic logic [13:0] period_ticks(input logic [4:0] code);
    case (code)
      5'd31:   period_ticks = 14'd260;
      5'd30:   period_ticks = 14'd297;
      5'd29:   period_ticks = 14'd347;
      5'd28:   period_ticks = 14'd416;
      5'd27:   period_ticks = 14'd520;
      5'd26:   period_ticks = 14'd628;
      5'd25:   period_ticks = 14'd783;
      5'd24:   period_ticks = 14'd1040;
      5'd23:   period_ticks = 14'd1073;
      5'd22:   period_ticks = 14'd1109;
      5'd21:   period_ticks = 14'd1148;
      5'd20:   period_ticks = 14'd1189;
      5'd19:   period_ticks = 14'd1232;
      5'd18:   period_ticks = 14'd1280;
      5'd17:   period_ticks = 14'd1331;
      5'd16:   period_ticks = 14'd1387;
      5'd15:   period_ticks = 14'd1447;
      5'd14:   period_ticks = 14'd1512;
      5'd13:   period_ticks = 14'd1585;
      5'd12:   period_ticks = 14'd1664;
      5'd11:   period_ticks = 14'd1751;
      5'd10:   period_ticks = 14'd1848;
      5'd9:    period_ticks = 14'd1958;
      5'd8:    period_ticks = 14'd2080;
      5'd7:    period_ticks = 14'd2294;
      5'd6:    period_ticks = 14'd2560;
      5'd5:    period_ticks = 14'd2894;
      5'd4:    period_ticks = 14'd3327;
      5'd3:    period_ticks = 14'd4160;
      5'd2:    period_ticks = 14'd4753;
      5'd1:    period_ticks = 14'd6053;
      default: period_ticks = 14'd8320;
    endcase
  endfunction

  // Period code offered for each resistor range, per generation clock
  function automatic logic [4:0] freq_set_resistor_code(input logic [1:0] sel, input logic [2:0] idx);
    case (sel)
      2'd0:    freq_set_resistor_code = 5'd31 - {2'b00, idx};
      2'd1: begin
        case (idx)
          3'd0:    freq_set_resistor_code = 5'd27;
          3'd1:    freq_set_resistor_code = 5'd26;
          3'd2:    freq_set_resistor_code = 5'd25;
          3'd3:    freq_set_resistor_code = 5'd24;
          3'd4:    freq_set_resistor_code = 5'd21;
          3'd5:    freq_set_resistor_code = 5'd18;
          3'd6:    freq_set_resistor_code = 5'd13;
          default: freq_set_resistor_code = 5'd8;
        endcase
      end
      2'd2: begin
        case (idx)
          3'd0:    freq_set_resistor_code = 5'd24;
          3'd1:    freq_set_resistor_code = 5'd19;
          3'd2:    freq_set_resistor_code = 5'd16;
          3'd3:    freq_set_resistor_code = 5'd12;
          3'd4:    freq_set_resistor_code = 5'd8;
          3'd5:    freq_set_resistor_code = 5'd6;
          3'd6:    freq_set_resistor_code = 5'd4;
          default: freq_set_resistor_code = 5'd3;
        endcase
      end
      default: begin
        case (idx)
          3'd0:    freq_set_resistor_code = 5'd8;
          3'd1:    freq_set_resistor_code = 5'd7;
          3'd2:    freq_set_resistor_code = 5'd6;
          3'd3:    freq_set_resistor_code = 5'd4;
          3'd4:    freq_set_resistor_code = 5'd3;
          3'd5:    freq_set_resistor_code = 5'd2;
          3'd6:    freq_set_resistor_code = 5'd1;
          default: freq_set_resistor_code = 5'd0;
        endcase
      end
    endcase
  endfunction

endpackage

// File: src/lpd_sloper.sv
// Purpose: Linear brightness ramp from current value to a new target
// Assumes: Single 10 MHz clock, target from same domain
// Notes:   Moves at most one LSB per cycle unless slope code is 0 (jumps to target), so very short spans slow down
`timescale 1ns/1ps
module lpd_sloper #(
  parameter int unsigned SLOPE_FULL_CYC = lpd_pkg::SLOPE_MAX_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control
  input  wire logic [15:0] target,
  input  wire logic [3:0]  slope_code,
  // Ramp output
  output logic      [15:0] value_q,
  output logic             ramping
);

  logic [15:0] tgt_q;
  logic [31:0] acc_q;
  logic [15:0] delta_q;
  logic        up_q;
  logic [35:0] prod;
  logic [31:0] span;
  logic [32:0] acc_sum;

  // Same span for rising and falling ramps
  assign prod    = 36'(slope_code) * 36'(SLOPE_FULL_CYC);
  assign span    = 32'(prod / 36'(lpd_pkg::SLOPE_CODES));
  assign acc_sum = {1'b0, acc_q} + {17'h0, delta_q};
  assign ramping = (value_q != tgt_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgt_q   <= 16'h0000;
      value_q <= 16'h0000;
      acc_q   <= 32'h0000_0000;
      delta_q <= 16'h0000;
      up_q    <= 1'b0;
    end else if (target != tgt_q) begin
      tgt_q   <= target;
      acc_q   <= 32'h0000_0000;
      up_q    <= (target > value_q);
      delta_q <= (target > value_q) ? (target - value_q) : (value_q - target);
    end else if (value_q != tgt_q) begin
      if (slope_code == 4'h0) begin
        value_q <= tgt_q;
      end else if (acc_sum >= {1'b0, span}) begin
        // Bresenham step keeps the whole ramp at the configured span when span is no shorter than delta_q
        acc_q   <= 32'(acc_sum - {1'b0, span});
        value_q <= up_q ? (value_q + 16'h0001) : (value_q - 16'h0001);
      end else begin
        acc_q <= acc_sum[31:0];
      end
    end
  end

endmodule

// File: testbench/lpd_checker.sv
// Purpose: Port-level assertions for the LED PWM core
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to the core from the bench top file
`timescale 1ns/1ps
module lpd_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // LED drive
  input wire logic [5:0]  led_out,
  input wire logic [7:0]  current_level
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  rd_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  wr_answer_a: assert property (wr_take |-> ##[2:3] s_axi_bvalid)
    else $error("write answer late");
  wr_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h14
    |=> s_axi_rvalid && s_axi_rresp == lpd_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Reset must win even while reset is low, so no disable here
  reset_state_a: assert property (disable iff (1'b0) !aresetn |=> current_level == 8'hff && led_out == 6'h00)
    else $error("reset state wrong");
endmodule

// File: testbench/lpd_bench.sv
// Purpose: Self-checking bench for the LED PWM core
// Assumes: 10 MHz aclk, shortened ramp parameter
// Notes:   Random stimulus from a bench LFSR seeded at 1
`timescale 1ns/1ps
module led_pwm_slope_dither_phase_bench;
  localparam int unsigned FULL = 15000;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, cre;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic [12:0] duty_in = 13'h0;
  logic        pwm_in = 1'b0;
  logic [2:0]  fsr = 3'h0;
  logic [5:0]  led_out;
  logic [7:0]  current_level;
  logic [15:0] lfsr = 16'h0001;
  int          errors = 0;
  int          comparisons = 0;
  logic [5:0]  hist [0:2079];
  logic        pin_h [0:3];

  lpd_pwm_core #(.SLOPE_FULL_CYC(FULL)) lpd_pwm_core_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .detected_duty(duty_in), .pwm_in(pwm_in), .freq_set_resistor(fsr),
    .led_out(led_out), .current_level(current_level), .current_resistor_enable(cre)
  );

  initial begin
    forever #50 aclk = ~aclk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  always @(posedge aclk) begin
    lfsr <= lfsr_next(lfsr);
    duty_in <= lfsr[12:0];
    pwm_in <= lfsr[0];
  end

  task automatic summarize();
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 40) begin
      errors++;
      summarize();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    if (n == 40) begin
      errors++;
      summarize();
    end
  endtask

  function automatic logic [31:0] cfg(input int src, fres, stag, code, sel, dith, slope);
    lpd_pkg::lpd_cfg_s c;
    c = '{1'b0, src[1:0], fres[0], stag[0], code[4:0], sel[1:0], dith[1:0], slope[3:0]};
    return {14'h0, c};
  endfunction

  function automatic int res_exp(input int c);
    return c >= 28 ? 8 : c >= 25 ? 9 : c >= 9 ? 10 : c >= 4 ? 11 : c >= 1 ? 12 : 13;
  endfunction

  initial begin
    logic [31:0] d;
    int          hi;
    int          du;
    int          t0;
    logic        dith_seen;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, d);
    chk(d, 32'h0);
    rd(8'h08, d);
    chk(d, 32'hff);
    d = {24'h0, lfsr[7:0]};
    wr(8'h08, d);
    chk(current_level, d);
    wr(8'h00, 32'h20000);
    chk(cre, 1'b1);
    rd(8'h14, d);
    chk(rresp, lpd_pkg::RESP_SLVERR);
    // Every code at the fastest clock; unavailable pairs fall back
    for (int c = 0; c < 32; c++) begin
      wr(8'h00, cfg(2, 0, 0, c, 3, 0, 0));
      rd(8'h0c, d);
      chk(d[20:17], res_exp(c));
      chk(d[22:21], res_exp(c) > 10 ? 3 : res_exp(c) - 8);
    end
    // Fastest and slowest resistor range on every clock
    for (int i = 0; i < 8; i += 7) begin
      fsr <= i[2:0];
      for (int g = 0; g < 4; g++) begin
        wr(8'h00, cfg(2, 1, 0, 0, g, 0, 0));
        repeat (4) @(posedge aclk);
        rd(8'h0c, d);
        chk(d[20:17], 8 + g + (i ? 2 : 0));
        chk(d[22:21], g);
      end
    end
    // One full period per stagger setting, channels compared to channel 0
    for (int s = 0; s < 2; s++) begin
      d = {24'h0, lfsr[7:1], 1'b1};
      wr(8'h04, d);
      // One tick per cycle; first pass waits out the long period begun after reset
      wr(8'h00, cfg(2, 0, s, 8, 3, 0, 0));
      repeat (s ? 4200 : 10500) @(posedge aclk);
      hi = 0;
      for (int t = 0; t < 2080; t++) begin
        @(posedge aclk);
        hist[t] = led_out;
        hi += led_out[0];
      end
      chk(hi, d * 8);
      for (int k = 1; k < 6; k++) begin
        du = 0;
        for (int t = 0; t < 2080; t++) du += (hist[t][k] !== hist[(t + 2080 - k * s * (2080 / 6)) % 2080][0]);
        chk(du, 0);
      end
    end
    wr(8'h00, cfg(3, 0, 1, 31, 0, 3, 0));
    du = 0;
    for (int t = 0; t < 64; t++) begin
      @(posedge aclk);
      pin_h[t % 4] = pwm_in;
      if (t > 3) du += (led_out !== {6{pin_h[(t + 1) % 4]}});
    end
    chk(du, 0);
    // Ramp up then down over the same span, dither allowed
    wr(8'h04, 32'h20);
    wr(8'h00, cfg(2, 0, 0, 8, 3, 3, 0));
    repeat (8) @(posedge aclk);
    wr(8'h00, cfg(2, 0, 0, 8, 3, 3, 4));
    for (int i = 0; i < 2; i++) begin
      t0 = $time / 100;
      wr(8'h04, i ? 32'h20 : 32'h24);
      dith_seen = 1'b0;
      for (du = 0; du < 3000; du++) begin
        rd(8'h10, d);
        dith_seen |= d[14];
        rd(8'h0c, d);
        if (!d[16]) break;
      end
      if (du == 3000) begin
        errors++;
        summarize();
      end
      hi = $time / 100 - t0;
      chk(hi > 3900 && hi < 4100, 1'b1);
      chk(d[15:0], i ? 16'h2000 : 16'h2400);
      chk(dith_seen, 1'b1);
      // Duty latches per period, so let one full period pass once steady
      repeat (2100) @(posedge aclk);
      rd(8'h10, d);
      chk(d[14], 1'b0);
    end
    summarize();
  end
endmodule

bind lpd_pwm_core lpd_checker lpd_checker_i (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .led_out(led_out), .current_level(current_level)
);
